// ===== swd_drop_report.sv
// drop-event capture, interrupt mask and port 2 learn-discard counter
`timescale 1ns/1ps
`default_nettype none

module swd_drop_report
   import swd_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   // register port
   input  wire swd_pkg::swd_reg_req_s reg_req,
   output var  logic [31:0]           reg_rdata_ff,
   output var  logic                  reg_rvalid_ff,
   // drop events from the forwarding logic
   input  wire logic                  drop_event,
   input  wire logic [1:0]            drop_src_port,
   input  wire swd_pkg::swd_cond_s    drop_cond,
   // learning engine
   input  wire logic                  learn_discard_p2,
   // interrupt toward system interrupt logic
   output var  logic                  irq_ff
);
   import swd_pkg::*;

   logic [31:0] discard_cnt_ff;
   logic [31:0] nxt_discard_cnt;
   logic        mask_ff;
   logic        nxt_mask;
   swd_pend_s   pend_ff;
   swd_pend_s   nxt_pend;
   logic [31:0] nxt_rdata;

   // register decode
   wire sel_cnt  = reg_req.addr == SWD_REG_LEARN_DISCARD_P2;
   wire sel_mask = reg_req.addr == SWD_REG_INT_MASK;
   wire sel_pend = reg_req.addr == SWD_REG_INT_PENDING;
   wire rd_cnt   = reg_req.rd && sel_cnt;
   wire rd_pend  = reg_req.rd && sel_pend;
   wire wr_mask  = reg_req.wr && sel_mask;

   // reason classification from the packet's conditions
   wire unk         = !drop_cond.da_known;
   wire kn          = drop_cond.da_known;
   wire h_vid       = drop_cond.vid_all_ones;
   wire h_untag     = drop_cond.admit_only_tagged && drop_cond.untagged_or_prio;
   wire h_bthrot    = drop_cond.da_bcast && drop_cond.bcast_throttled;
   wire h_unk_fwd   = unk && !drop_cond.src_forwarding;
   wire h_unk_memb  = unk && drop_cond.member_check && !drop_cond.admit_non_member
                      && !drop_cond.src_in_vlan;
   wire h_unk_uc    = unk && !drop_cond.da_bcast && !drop_cond.da_mcast
                      && drop_cond.drop_unknown;
   wire h_unk_mc    = unk && drop_cond.da_mcast && !drop_cond.da_bcast
                      && drop_cond.filter_mcast;
   wire h_kn_sfwd   = kn && !drop_cond.src_forwarding;
   wire h_kn_dfwd   = kn && !drop_cond.dst_forwarding;
   wire h_kn_dmemb  = kn && drop_cond.member_check && !drop_cond.dst_in_vlan;
   wire h_kn_smemb  = kn && drop_cond.member_check && !drop_cond.admit_non_member
                      && !drop_cond.src_in_vlan;
   wire h_kn_same   = kn && drop_cond.same_port;
   wire h_kn_filt   = kn && drop_cond.filter_attr;

   // priority follows the order checks are made on ingress; reserved codes unreachable
   wire [3:0] reason =
      h_vid      ? SWD_RSN_VID_ALL_ONES :
      h_untag    ? SWD_RSN_ADMIT_TAGGED :
      h_bthrot   ? SWD_RSN_BCAST_THROT  :
      h_unk_fwd  ? SWD_RSN_UNK_SRC_FWD  :
      h_unk_memb ? SWD_RSN_UNK_SRC_MEMB :
      h_unk_uc   ? SWD_RSN_DROP_UNK_UC  :
      h_unk_mc   ? SWD_RSN_FILT_UNK_MC  :
      h_kn_sfwd  ? SWD_RSN_KN_SRC_FWD   :
      h_kn_dfwd  ? SWD_RSN_KN_DST_FWD   :
      h_kn_dmemb ? SWD_RSN_KN_DST_MEMB  :
      h_kn_smemb ? SWD_RSN_KN_SRC_MEMB  :
      h_kn_same  ? SWD_RSN_KN_SAME_PORT :
                   SWD_RSN_KN_FILTER;

   wire any_hit = h_vid || h_untag || h_bthrot || h_unk_fwd || h_unk_memb
                  || h_unk_uc || h_unk_mc || h_kn_sfwd || h_kn_dfwd
                  || h_kn_dmemb || h_kn_smemb || h_kn_same || h_kn_filt;
   // a drop with no recognised cause is not recorded
   wire ev = drop_event && any_hit;

   // a read clears first, then the new event lands, so an event in the reading cycle is not lost
   wire a_free = !pend_ff.a_valid || rd_pend;
   wire b_free = !pend_ff.b_valid || rd_pend;
   wire cap_a  = ev && a_free;
   wire cap_b  = ev && !a_free && b_free;

   always_comb
   begin
      nxt_pend = pend_ff;
      if (rd_pend)
      begin
         nxt_pend = '0;
      end
      nxt_pend.rsvd = SWD_PEND_RSVD;
      if (ev)
      begin
         nxt_pend.pending = 1'b1;
      end
      if (cap_a)
      begin
         nxt_pend.a_valid  = 1'b1;
         nxt_pend.a_port   = drop_src_port;
         nxt_pend.a_reason = reason;
      end
      if (cap_b)
      begin
         nxt_pend.b_valid  = 1'b1;
         nxt_pend.b_port   = drop_src_port;
         nxt_pend.b_reason = reason;
      end
   end

   // counter: clear on read, then count the event of the same cycle
   wire [31:0] cnt_base = rd_cnt ? SWD_RST_LEARN_DISCARD : discard_cnt_ff;
   wire        cnt_sat  = cnt_base == SWD_CNT_MAX;
   assign nxt_discard_cnt = (learn_discard_p2 && !cnt_sat)
                            ? cnt_base + SWD_CNT_ONE
                            : cnt_base;

   assign nxt_mask = wr_mask ? reg_req.wdata[SWD_MASK_BIT] : mask_ff;

   // read data mux; unmapped numbers read zero
   assign nxt_rdata = sel_cnt  ? discard_cnt_ff :
                      sel_pend ? pend_ff :
                      sel_mask ? {SWD_MASK_RSVD, mask_ff} :
                                 SWD_RD_UNMAPPED;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         discard_cnt_ff <= SWD_RST_LEARN_DISCARD;
         mask_ff        <= SWD_RST_INT_MASK;
         pend_ff        <= '0;
         irq_ff         <= 1'b0;
         reg_rdata_ff   <= SWD_RD_UNMAPPED;
         reg_rvalid_ff  <= 1'b0;
      end
      else
      begin
         discard_cnt_ff <= nxt_discard_cnt;
         mask_ff        <= nxt_mask;
         pend_ff        <= nxt_pend;
         irq_ff         <= nxt_pend.pending && !nxt_mask;
         reg_rvalid_ff  <= reg_req.rd;
         if (reg_req.rd)
         begin
            reg_rdata_ff <= nxt_rdata;
         end
      end
   end

endmodule : swd_drop_report

`default_nettype wire

// ===== swd_drop_report_sva.sv
// assertions on the drop-report block ports
`timescale 1ns/1ps
`default_nettype none
module swd_drop_report_sva
   import swd_pkg::*;
(
   // watched ports
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire swd_pkg::swd_reg_req_s reg_req,
   input wire logic [31:0]           reg_rdata_ff,
   input wire logic                  reg_rvalid_ff,
   input wire logic                  drop_event,
   input wire logic [1:0]            drop_src_port,
   input wire swd_pkg::swd_cond_s    drop_cond,
   input wire logic                  learn_discard_p2,
   input wire logic                  irq_ff
);
   logic      mask_ff;
   wire logic rd_p = reg_req.rd && reg_req.addr == 16'h1881;
   wire logic rd_c = reg_req.rd && reg_req.addr == 16'h185a;
   wire logic rd_m = reg_req.rd && reg_req.addr == 16'h1880;
   wire logic wr_m = reg_req.wr && reg_req.addr == 16'h1880;
   // own copy of the mask, so irq is judged without peeking inside
   always_ff @(posedge clock)
      mask_ff <= !rst_n ? 1'h1 : wr_m ? reg_req.wdata[0] : mask_ff;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_pend_rd; rd_p && !drop_event; endsequence
   sequence s_cnt_rd; rd_c && !learn_discard_p2; endsequence
   sequence s_drop; drop_event && drop_cond.vid_all_ones && !reg_req.rd && !wr_m; endsequence
   a_read_answer: assert property (reg_req.rd |=> reg_rvalid_ff)
      else $error("read not answered");
   a_no_stray_answer: assert property (!reg_req.rd |=> !reg_rvalid_ff)
      else $error("answer without read");
   a_mask_gates_irq: assert property (irq_ff |-> !mask_ff)
      else $error("irq while masked");
   a_drop_raises_irq: assert property (s_drop ##0 !mask_ff |=> irq_ff)
      else $error("unmasked drop gave no irq");
   a_read_drops_irq: assert property (s_pend_rd |=> !irq_ff)
      else $error("irq stayed after pending read");
   a_pend_clears: assert property (s_pend_rd ##1 s_pend_rd |=> reg_rdata_ff == 32'h0)
      else $error("pending not cleared by read");
   a_cnt_clears: assert property (s_cnt_rd ##1 s_cnt_rd |=> reg_rdata_ff == 32'h0)
      else $error("counter not cleared by read");
   a_mask_reads: assert property (rd_m |=> reg_rdata_ff == {31'h0, $past(mask_ff)})
      else $error("mask read wrong");
endmodule : swd_drop_report_sva
bind swd_drop_report swd_drop_report_sva i_swd_drop_report_sva (.clock(clock), .rst_n(rst_n),
   .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
   .drop_event(drop_event), .drop_src_port(drop_src_port), .drop_cond(drop_cond),
   .learn_discard_p2(learn_discard_p2), .irq_ff(irq_ff));
`default_nettype wire

// ===== swd_pkg.sv
// package for the switch drop-event reporting block: register map, fields, carriers
package swd_pkg;

   // register numbers on the switch engine register port
   localparam logic [15:0] SWD_REG_LEARN_DISCARD_P2 = 16'h185a;
   localparam logic [15:0] SWD_REG_INT_MASK         = 16'h1880;
   localparam logic [15:0] SWD_REG_INT_PENDING      = 16'h1881;

   // reset values, counter limit and increment
   localparam logic [31:0] SWD_RST_LEARN_DISCARD = 32'h0000_0000;
   localparam logic        SWD_RST_INT_MASK      = 1'h1;
   localparam logic [31:0] SWD_CNT_MAX           = 32'hffff_ffff;
   localparam logic [31:0] SWD_CNT_ONE           = 32'h0000_0001;
   localparam logic [31:0] SWD_RD_UNMAPPED       = 32'h0000_0000;

   // mask register layout: bit 0 is the mask, the rest reads zero
   localparam int          SWD_MASK_BIT   = 0;
   localparam logic [30:0] SWD_MASK_RSVD  = 31'h0000_0000;
   localparam logic [16:0] SWD_PEND_RSVD  = 17'h0_0000;

   // source port codes
   localparam logic [1:0] SWD_PORT_0   = 2'h0;
   localparam logic [1:0] SWD_PORT_1   = 2'h1;
   localparam logic [1:0] SWD_PORT_2   = 2'h2;
   localparam logic [1:0] SWD_PORT_RSV = 2'h3;

   // drop reason codes
   localparam logic [3:0] SWD_RSN_ADMIT_TAGGED  = 4'h0;
   localparam logic [3:0] SWD_RSN_UNK_SRC_MEMB  = 4'h1;
   localparam logic [3:0] SWD_RSN_KN_SRC_FWD    = 4'h2;
   localparam logic [3:0] SWD_RSN_KN_DST_FWD    = 4'h3;
   localparam logic [3:0] SWD_RSN_KN_DST_MEMB   = 4'h4;
   localparam logic [3:0] SWD_RSN_KN_SRC_MEMB   = 4'h5;
   localparam logic [3:0] SWD_RSN_DROP_UNK_UC   = 4'h6;
   localparam logic [3:0] SWD_RSN_FILT_UNK_MC   = 4'h7;
   localparam logic [3:0] SWD_RSN_BCAST_THROT   = 4'h8;
   localparam logic [3:0] SWD_RSN_UNK_SRC_FWD   = 4'h9;
   localparam logic [3:0] SWD_RSN_KN_SAME_PORT  = 4'ha;
   localparam logic [3:0] SWD_RSN_KN_FILTER     = 4'hb;
   localparam logic [3:0] SWD_RSN_VID_ALL_ONES  = 4'he;

   // conditions seen by the forwarding logic for one dropped packet
   typedef struct packed {
      logic admit_only_tagged;
      logic untagged_or_prio;
      logic da_known;
      logic da_bcast;
      logic da_mcast;
      logic member_check;
      logic admit_non_member;
      logic src_in_vlan;
      logic dst_in_vlan;
      logic src_forwarding;
      logic dst_forwarding;
      logic drop_unknown;
      logic filter_mcast;
      logic bcast_throttled;
      logic same_port;
      logic filter_attr;
      logic vid_all_ones;
   } swd_cond_s;

   // register port request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [31:0] wdata;
   } swd_reg_req_s;

   // pending register image, msb first
   typedef struct packed {
      logic [16:0] rsvd;
      logic [3:0]  b_reason;
      logic [1:0]  b_port;
      logic        b_valid;
      logic [3:0]  a_reason;
      logic [1:0]  a_port;
      logic        a_valid;
      logic        pending;
   } swd_pend_s;

endpackage : swd_pkg

// ===== tb.sv
// self-checking bench for the drop-report block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import swd_pkg::*;
   logic         clock = 1'b0;
   logic         rst_n = 1'b0;
   swd_reg_req_s req   = '0;
   swd_cond_s    cond  = '0;
   logic [31:0]  rdata;
   logic         rvalid, irq;
   logic         drop_event = 1'b0;
   logic         learn      = 1'b0;
   logic [1:0]   port = 2'h0, pa, pb;
   integer       seed = 20197, n_errors = 0, check_count = 0, n;
   // flags flipped from a baseline that matches no cause, one entry per code
   localparam logic [3:0]  CODE [13] = '{4'he, 4'h0, 4'h8, 4'h9, 4'h1, 4'h6, 4'h7,
      4'h2, 4'h3, 4'h4, 4'h5, 4'ha, 4'hb};
   localparam logic [16:0] FLIP [13] = '{17'h00001, 17'h18000, 17'h06008, 17'h04080,
      17'h04e00, 17'h04020, 17'h05010, 17'h00080, 17'h00040, 17'h00900, 17'h00e00,
      17'h00004, 17'h00002};
   always #25 clock = ~clock;
   swd_drop_report i_swd_drop_report (.clock(clock), .rst_n(rst_n), .reg_req(req),
      .reg_rdata_ff(rdata), .reg_rvalid_ff(rvalid), .drop_event(drop_event),
      .drop_src_port(port), .drop_cond(cond), .learn_discard_p2(learn), .irq_ff(irq));
   function automatic logic [31:0] image(input logic [3:0] ra, input logic [1:0] pa_,
      input logic bv, input logic [3:0] rb, input logic [1:0] pb_);
      return {SWD_PEND_RSVD, rb, pb_, bv, ra, pa_, 2'h3};
   endfunction : image
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // reads twice back to back: the second shows what the first left behind
   task automatic rd(input logic [15:0] a, input logic p, input logic [31:0] e1, e2);
      @(posedge clock);
      req.rd <= 1'b1;
      req.addr <= a;
      learn <= p;
      @(posedge clock);
      learn <= 1'b0;
      #1 chk({31'h0, rvalid}, 32'h1);
      chk(rdata, e1);
      @(posedge clock);
      req.rd <= 1'b0;
      #1 chk(rdata, e2);
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clock);
      req.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic drop(input logic [1:0] p, input int k);
      @(posedge clock);
      drop_event <= 1'b1;
      port <= p;
      cond <= swd_cond_s'(17'h047c0 ^ FLIP[k]);
      @(posedge clock);
      drop_event <= 1'b0;
      #1;
   endtask : drop
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   initial
   begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      rd(16'h185a, 1'b0, 32'h0, 32'h0);
      rd(16'h1880, 1'b0, 32'h1, 32'h1);
      rd(16'h1881, 1'b0, 32'h0, 32'h0);
      rd(16'h1882, 1'b0, SWD_RD_UNMAPPED, SWD_RD_UNMAPPED);
      drop(2'h1, 0);
      chk({31'h0, irq}, 32'h0);
      wr(16'h1880, {31'($random(seed)), 1'b0});
      chk({31'h0, irq}, 32'h1);
      rd(16'h1881, 1'b0, image(4'he, 2'h1, 1'b0, 4'h0, 2'h0), 32'h0);
      chk({31'h0, irq}, 32'h0);
      // third drop must leave both sets untouched
      for (int i = 0; i < 13; i++)
      begin
         pa = 2'($unsigned($random(seed)) % 3);
         pb = 2'($unsigned($random(seed)) % 3);
         drop(pa, i);
         drop(pb, (i + 1) % 13);
         drop(pa, (i + 2) % 13);
         chk({31'h0, irq}, 32'h1);
         rd(16'h1881, 1'b0, image(CODE[i], pa, 1'b1, CODE[(i + 1) % 13], pb), 32'h0);
      end
      // masking again drops the request but keeps the record
      drop(2'h2, 3);
      chk({31'h0, irq}, 32'h1);
      wr(16'h1880, {31'($random(seed)), 1'b1});
      chk({31'h0, irq}, 32'h0);
      rd(16'h1880, 1'b0, 32'h1, 32'h1);
      rd(16'h1881, 1'b0, image(4'h9, 2'h2, 1'b0, 4'h0, 2'h0), 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(16'h185a, 32'($random(seed)));
      n = 1 + $unsigned($random(seed)) % 20;
      @(posedge clock);
      learn <= 1'b1;
      repeat (n) @(posedge clock);
      learn <= 1'b0;
      // pulse during the clearing read must survive as a count of one
      rd(16'h185a, 1'b1, 32'(n), 32'h1);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
